// file: logic/drs_dram_read_sched.sv
// Device side of read and interleaved row/column/close request handling
`timescale 1ns/10ps
module drs_dram_read_sched #(
    parameter int READ_LATENCY = drs_pkg::READ_LATENCY,
    parameter int CAS_TO_CAS_INTERVAL = drs_pkg::CAS_TO_CAS_INTERVAL
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic requestClk,
    input wire drs_pkg::drs_req_t requestLanes,
    output drs_pkg::drs_data_t readData,
    output logic [drs_pkg::NUM_BANKS-1:0] bankOpenMask,
    output logic protocolError
);
    localparam int NB = drs_pkg::NUM_BANKS;

    // Data pattern returned for a column; no core array behind it
    function automatic logic [drs_pkg::DATA_W-1:0] readPattern(
        input drs_pkg::drs_read_t rd
    );
        readPattern = {rd.bank, rd.row[6:0], rd.col};
    endfunction : readPattern

    // One-hot bank select, shared by both close paths
    function automatic logic [NB-1:0] bankOneHot(input logic [drs_pkg::BANK_W-1:0] bank);
        bankOneHot = NB'(1) << bank;
    endfunction : bankOneHot

    // Link-side reset: asserts at once, releases on a request clock edge
    logic [1:0] linkRstPipe_r;
    wire linkRst_n = linkRstPipe_r[1];
    always_ff @(posedge requestClk or negedge reset_n) begin
        if (!reset_n) begin
            linkRstPipe_r <= 2'b00;
        end else begin
            linkRstPipe_r <= {linkRstPipe_r[0], 1'b1};
        end
    end

    // Per-bank state: only the device's own view, no row comparison
    logic [NB-1:0] bankOpen_r;                    // Bank holds a sensed row
    logic [drs_pkg::ROW_W-1:0] openRow_r [NB];    // Row in each bank's sense amps
    logic shiftHeld_r;                            // Slot-shifted column waiting
    drs_pkg::drs_read_t shiftRead_r;              // Its address
    logic closePend_r;                            // Delayed close waiting
    logic [drs_pkg::BANK_W-1:0] closeBank_r;      // Bank of the delayed close
    logic [drs_pkg::DELAY_W-1:0] closeCnt_r;      // Cycles left before it acts
    drs_pkg::drs_read_t latPipe_r [READ_LATENCY]; // Read latency pipeline
    logic [drs_pkg::CNT_W-1:0] dataHold_r;        // Cycles left on the data lanes
    logic [drs_pkg::CNT_W-1:0] sinceCol_r;        // Cycles since last column read
    logic linkError_r;                            // Sticky protocol error

    // Request decode
    wire isOpen = (requestLanes.cmd == drs_pkg::DRS_ROW_OPEN);
    wire isRead = (requestLanes.cmd == drs_pkg::DRS_COLUMN_READ);
    wire isClose = (requestLanes.cmd == drs_pkg::DRS_BANK_CLOSE);
    wire readNow = isRead && !requestLanes.casSlotShift;
    wire readEarly = isRead && requestLanes.casSlotShift;
    wire closeNow = isClose && (requestLanes.closeDelay == '0);
    wire closeLater = isClose && (requestLanes.closeDelay != '0);

    // Column that executes in this slot: direct or one slot late
    drs_pkg::drs_read_t directRead;
    assign directRead = '{valid: readNow, bank: requestLanes.bank,
                          row: openRow_r[requestLanes.bank], col: requestLanes.col};
    wire drs_pkg::drs_read_t colExec = shiftHeld_r ? shiftRead_r : directRead;

    // Closes that act in this slot; a direct and a delayed one may meet, both must act
    wire pendFires = closePend_r && (closeCnt_r == drs_pkg::DELAY_W'(1));
    wire [NB-1:0] closeNowMask = closeNow ? bankOneHot(requestLanes.bank) : '0;
    wire [NB-1:0] closePendMask = pendFires ? bankOneHot(closeBank_r) : '0;
    wire [NB-1:0] closeMask = closeNowMask | closePendMask;

    // Violations the device can see on its own pins
    wire colClash = shiftHeld_r && readNow;
    wire colClosed = colExec.valid && !bankOpen_r[colExec.bank];
    wire colTooSoon = colExec.valid &&
        (sinceCol_r < drs_pkg::CNT_W'(CAS_TO_CAS_INTERVAL));
    wire closeClash = closePend_r && !pendFires && closeLater; // Older one acting now is legal
    wire openBusy = isOpen && bankOpen_r[requestLanes.bank];
    wire anyError = colClash || colClosed || colTooSoon || closeClash || openBusy;

    // Slot-shift hold: the early packet acts one request cycle later
    always_ff @(posedge requestClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            shiftHeld_r <= 1'b0;
            shiftRead_r <= drs_pkg::READ_IDLE;
        end else begin
            shiftHeld_r <= readEarly;
            shiftRead_r <= '{valid: readEarly, bank: requestLanes.bank,
                             row: openRow_r[requestLanes.bank], col: requestLanes.col};
        end
    end

    // Delayed bank close: one outstanding at a time
    always_ff @(posedge requestClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            closePend_r <= 1'b0;
            closeBank_r <= '0;
            closeCnt_r <= '0;
        end else if (closeLater) begin
            // A newer delayed close replaces an older one; flagged unless the older acts now
            closePend_r <= 1'b1;
            closeBank_r <= requestLanes.bank;
            closeCnt_r <= requestLanes.closeDelay;
        end else if (closePend_r) begin
            closePend_r <= !pendFires;
            closeCnt_r <= closeCnt_r - drs_pkg::DELAY_W'(1);
        end
    end

    // Bank state: open on row open, closed when a close acts
    always_ff @(posedge requestClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            bankOpen_r <= '0;
        end else begin
            for (int b = 0; b < NB; b++) begin
                if (isOpen && requestLanes.bank == drs_pkg::BANK_W'(b)) begin
                    bankOpen_r[b] <= 1'b1;
                end else if (closeMask[b]) begin
                    bankOpen_r[b] <= 1'b0;
                end
            end
        end
    end

    // Row latch per bank; row only matters while the bank is open
    always_ff @(posedge requestClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            for (int b = 0; b < NB; b++) begin
                openRow_r[b] <= '0;
            end
        end else if (isOpen) begin
            openRow_r[requestLanes.bank] <= requestLanes.row;
        end
    end

    // Latency pipeline: a column enters at its execution slot
    always_ff @(posedge requestClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            for (int i = 0; i < READ_LATENCY; i++) begin
                latPipe_r[i] <= drs_pkg::READ_IDLE;
            end
        end else begin
            latPipe_r[0] <= colExec;
            for (int i = 1; i < READ_LATENCY; i++) begin
                latPipe_r[i] <= latPipe_r[i-1];
            end
        end
    end

    // Data lanes: each packet stands for one cas-to-cas interval
    wire drs_pkg::drs_read_t pipeOut = latPipe_r[READ_LATENCY-1];
    always_ff @(posedge requestClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            readData <= drs_pkg::DATA_IDLE;
            dataHold_r <= '0;
        end else if (pipeOut.valid) begin
            // Back-to-back packets leave no idle cycle
            readData <= '{valid: 1'b1, data: readPattern(pipeOut)};
            dataHold_r <= drs_pkg::CNT_W'(CAS_TO_CAS_INTERVAL - 1);
        end else if (dataHold_r != '0) begin
            dataHold_r <= dataHold_r - drs_pkg::CNT_W'(1);
        end else begin
            readData <= drs_pkg::DATA_IDLE;
        end
    end

    // Column spacing counter, saturating so a long gap never wraps
    always_ff @(posedge requestClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            sinceCol_r <= '1;
        end else if (colExec.valid) begin
            sinceCol_r <= drs_pkg::CNT_W'(1);
        end else if (sinceCol_r != '1) begin
            sinceCol_r <= sinceCol_r + drs_pkg::CNT_W'(1);
        end
    end

    // Sticky error; cleared only by reset, so no set/clear race exists
    always_ff @(posedge requestClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            linkError_r <= 1'b0;
        end else if (anyError) begin
            linkError_r <= 1'b1;
        end
    end

    // Status word into the system clock domain
    drs_pkg::drs_status_t linkStatus;
    drs_pkg::drs_status_t sysStatus;
    assign linkStatus = '{protocolError: linkError_r, bankOpen: bankOpen_r};

    drs_word_sync #(
        .WIDTH(drs_pkg::STATUS_W)
    ) u_status_sync (
        .srcClk(requestClk),
        .srcRst_n(linkRst_n),
        .srcWord(linkStatus),
        .dstClk(clk),
        .dstRst_n(reset_n),
        .dstWord(sysStatus)
    );

    // System side outputs, straight from the crossing's register
    assign bankOpenMask = sysStatus.bankOpen;
    assign protocolError = sysStatus.protocolError;
endmodule : drs_dram_read_sched

// file: logic/drs_pkg.sv
// Shared constants and types for the read scheduling device block
package drs_pkg;
    // Address and data widths
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int ROW_W = 12;
    localparam int COL_W = 6;
    localparam int DATA_W = 16;
    localparam int DELAY_W = 2;
    localparam int CNT_W = 4;
    // Timing in request clock cycles (request_period units)
    localparam int READ_LATENCY = 6;
    localparam int CAS_TO_CAS_INTERVAL = 2;
    localparam int CAS_SLOT_SHIFT_CYCLES = 1;
    // Synchroniser depth for every crossing
    localparam int SYNC_STAGES = 2;

    // Command carried by one request slot
    typedef enum logic [1:0] {
        DRS_NOP,
        DRS_ROW_OPEN,
        DRS_COLUMN_READ,
        DRS_BANK_CLOSE
    } drs_cmd_t;

    // One request packet on the request lanes
    typedef struct packed {
        drs_cmd_t cmd;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic casSlotShift;
        logic [DELAY_W-1:0] closeDelay;
    } drs_req_t;

    // Column read in flight toward the data lanes
    typedef struct packed {
        logic valid;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
    } drs_read_t;

    // Read data packet on the data lanes
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } drs_data_t;

    // Status word handed to the system clock domain
    typedef struct packed {
        logic protocolError;
        logic [NUM_BANKS-1:0] bankOpen;
    } drs_status_t;

    localparam int STATUS_W = $bits(drs_status_t);
    localparam drs_read_t READ_IDLE = '0;
    localparam drs_data_t DATA_IDLE = '0;
    localparam drs_status_t STATUS_RESET = '0;
endpackage : drs_pkg

// file: logic/drs_word_sync.sv
// Toggle handshake that carries a word from one clock domain to another
`timescale 1ns/10ps
module drs_word_sync #(
    parameter int WIDTH = 8
) (
    input wire logic srcClk,
    input wire logic srcRst_n,
    input wire logic [WIDTH-1:0] srcWord,
    input wire logic dstClk,
    input wire logic dstRst_n,
    output logic [WIDTH-1:0] dstWord
);
    logic [WIDTH-1:0] holdWord_r; // Stable while a toggle is in flight
    logic reqTog_r;               // Source request toggle
    logic [1:0] ackSync_r;        // Ack toggle into source domain
    logic [1:0] reqSync_r;        // Req toggle into destination domain
    logic ackTog_r;               // Destination ack toggle
    wire srcIdle = (ackSync_r[1] == reqTog_r);
    wire dstNew = (reqSync_r[1] != ackTog_r);

    // Source: resample only when the last word was taken
    always_ff @(posedge srcClk or negedge srcRst_n) begin
        if (!srcRst_n) begin
            holdWord_r <= '0;
            reqTog_r <= 1'b0;
            ackSync_r <= 2'b00;
        end else begin
            ackSync_r <= {ackSync_r[0], ackTog_r};
            if (srcIdle) begin
                holdWord_r <= srcWord;
                reqTog_r <= ~reqTog_r;
            end
        end
    end

    // Destination: word is stable once the toggle has passed two flops
    always_ff @(posedge dstClk or negedge dstRst_n) begin
        if (!dstRst_n) begin
            reqSync_r <= 2'b00;
            ackTog_r <= 1'b0;
            dstWord <= '0;
        end else begin
            reqSync_r <= {reqSync_r[0], reqTog_r};
            if (dstNew) begin
                dstWord <= holdWord_r;
                ackTog_r <= ~ackTog_r;
            end
        end
    end
endmodule : drs_word_sync

// file: verification/drs_sched_chk.sv
// Concurrent checks on the read scheduling device ports
`timescale 1ns/10ps
module drs_sched_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic requestClk,
    input wire drs_pkg::drs_req_t requestLanes,
    input wire drs_pkg::drs_data_t readData,
    input wire logic [drs_pkg::NUM_BANKS-1:0] bankOpenMask,
    input wire logic protocolError
);
    logic colU; // Column read executing on arrival
    logic colS; // Column read pulled one slot early
    assign colU = requestLanes.cmd == drs_pkg::DRS_COLUMN_READ && !requestLanes.casSlotShift;
    assign colS = requestLanes.cmd == drs_pkg::DRS_COLUMN_READ && requestLanes.casSlotShift;
    // All link checks live on the request clock
    default clocking cb @(posedge requestClk); endclocking
    default disable iff (!reset_n);
    sequence s_pair;
        colU ##2 colU;
    endsequence
    property p_lat; colU |-> ##7 readData.valid ##1 readData.valid; endproperty
    a_lat: assert property (p_lat) else $error("read data late or short");
    property p_slat; colS |-> ##8 readData.valid ##1 readData.valid; endproperty
    a_slat: assert property (p_slat) else $error("shifted read not one slot later");
    property p_bank; colU |-> ##7 readData.data[15:13] == $past(requestLanes.bank, 7); endproperty
    a_bank: assert property (p_bank) else $error("read data from wrong bank");
    property p_col; colU |-> ##7 readData.data[5:0] == $past(requestLanes.col, 7); endproperty
    a_col: assert property (p_col) else $error("read data from wrong column");
    property p_scol; colS |-> ##8 readData.data[5:0] == $past(requestLanes.col, 8); endproperty
    a_scol: assert property (p_scol) else $error("shifted read wrong column");
    property p_hold; $rose(readData.valid) |=> readData.valid && $stable(readData.data); endproperty
    a_hold: assert property (p_hold) else $error("read packet not held");
    property p_cause;
        readData.valid |-> $past(colU, 7) || $past(colU, 8) || $past(colS, 8) || $past(colS, 9);
    endproperty
    a_cause: assert property (p_cause) else $error("read data without column");
    property p_pair; s_pair |-> ##5 readData.valid [*4]; endproperty
    a_pair: assert property (p_pair) else $error("gap between back to back reads");
endmodule : drs_sched_chk

bind drs_dram_read_sched drs_sched_chk drs_sched_chk_i (.clk(clk), .reset_n(reset_n),
    .requestClk(requestClk), .requestLanes(requestLanes), .readData(readData),
    .bankOpenMask(bankOpenMask), .protocolError(protocolError));

// file: verification/drs_ctrl_model.sv
// Controller model playing fixed request packet programs
`timescale 1ns/10ps
module drs_ctrl_model (
    input wire logic requestClk,
    input wire logic start,
    input wire logic [1:0] mode,
    output drs_pkg::drs_req_t requestLanes,
    output logic busy,
    output logic [5:0] slot
);
    drs_pkg::drs_req_t pkt; // Packet of the current slot
    int s; // Slot as integer
    initial busy = 1'b0;
    initial slot = 6'h00;
    function automatic drs_pkg::drs_req_t mk(drs_pkg::drs_cmd_t c, int b, int r, int cl, int sh,
        int d);
        return '{c, 3'(b), 12'(r), 6'(cl), 1'(sh), 2'(d)};
    endfunction : mk
    // Slot counter moves on the falling edge, away from sampling
    always @(negedge requestClk) begin
        if (start) begin
            busy <= 1'b1;
            slot <= 6'h00;
        end else if (slot == 6'h27) begin
            busy <= 1'b0;
            slot <= 6'h00;
        end else if (busy) begin
            slot <= slot + 6'h01;
        end
    end
    // Program table; idle fields toggle so no stale value looks valid
    always_comb begin
        s = slot;
        pkt = mk(drs_pkg::DRS_NOP, ~s, ~s, s, 0, 0);
        if (mode == 2'h0) begin
            // Four-bank page-empty rotation in a fixed slot pattern
            // Distinct banks per transaction; no write program, so no five-bank case
            if (s % 4 == 0 && s < 16) begin
                pkt = mk(drs_pkg::DRS_ROW_OPEN, s / 4, s / 4 + 1, 0, 0, 0);
            end
            if (s % 2 == 1 && s >= 5 && s < 21) begin
                pkt = mk(drs_pkg::DRS_COLUMN_READ, (s - 5) / 4, 0, (s - 5) / 2, 0, 0);
            end
            // Closes four slots apart, one bank field per close packet
            if (s % 4 == 2 && s >= 10 && s < 26) begin
                pkt = mk(drs_pkg::DRS_BANK_CLOSE, (s - 10) / 4, 0, 0, 0, 0);
            end
        end else if (mode == 2'h1) begin
            // Hit, shifted column, delayed close, then reopen on a miss
            case (s)
                0: pkt = mk(drs_pkg::DRS_ROW_OPEN, 5, 3, 0, 0, 0);
                5: pkt = mk(drs_pkg::DRS_COLUMN_READ, 5, 0, 9, 0, 0);
                7: pkt = mk(drs_pkg::DRS_COLUMN_READ, 5, 0, 10, 1, 0);
                12: pkt = mk(drs_pkg::DRS_BANK_CLOSE, 5, 0, 0, 0, 2);
                18: pkt = mk(drs_pkg::DRS_ROW_OPEN, 5, 7, 0, 0, 0);
                23: pkt = mk(drs_pkg::DRS_COLUMN_READ, 5, 0, 1, 0, 0);
                default: ;
            endcase
        end else if (s == 0) begin
            pkt = mk(drs_pkg::DRS_COLUMN_READ, 6, 0, 4, 0, 0); // Read to a closed bank
        end
        if (!busy) pkt.cmd = drs_pkg::DRS_NOP;
    end
    assign requestLanes = pkt;
endmodule : drs_ctrl_model

// file: verification/drs_dram_read_sched_tb.sv
// Self-checking bench for the read scheduling device block
`timescale 1ns/10ps
module drs_dram_read_sched_tb;
    logic clk = 1'b0; // 20 MHz system clock
    logic reset_n = 1'b0;
    logic requestClk = 1'b0; // 15 ns link clock
    logic start = 1'b0;
    logic [1:0] mode = 2'h0;
    logic busy;
    logic [5:0] slot;
    drs_pkg::drs_req_t requestLanes;
    drs_pkg::drs_data_t readData;
    logic [drs_pkg::NUM_BANKS-1:0] bankOpenMask;
    logic protocolError;
    drs_pkg::drs_data_t rec [40]; // Read data seen per slot
    drs_pkg::drs_data_t expv [40]; // Read data expected per slot
    int error_cnt = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    // 15 ns against 50 ns: an edge of one clock meets an edge of the other every 75 ns
    always #7.5 requestClk = ~requestClk;
    drs_dram_read_sched #(.READ_LATENCY(6), .CAS_TO_CAS_INTERVAL(2)) drs_dram_read_sched_i (
        .clk(clk), .reset_n(reset_n), .requestClk(requestClk), .requestLanes(requestLanes),
        .readData(readData), .bankOpenMask(bankOpenMask), .protocolError(protocolError));
    drs_ctrl_model drs_ctrl_model_i (.requestClk(requestClk), .start(start), .mode(mode),
        .requestLanes(requestLanes), .busy(busy), .slot(slot));
    // Record data lanes mid-cycle; slot still holds its old value here
    always @(negedge requestClk) begin
        if (busy) rec[slot] = readData;
    end
    task automatic cmp_data(input int k);
        num_checks++;
        if (rec[k] !== expv[k]) begin
            error_cnt++;
            $display("CHECK FAILED readData slot %0d expected %h seen %h", k, expv[k], rec[k]);
        end
    endtask : cmp_data
    task automatic cmp_vec(input string name, input logic [8:0] e, input logic [8:0] v);
        num_checks++;
        if (v !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, v);
        end
    endtask : cmp_vec
    // Two-slot data packet for a column taken in slot j
    task automatic expect_col(input int j, input int sh, input int b, input int r, input int c);
        expv[j + 6 + sh] = {1'b1, 3'(b), 7'(r), 6'(c)};
        expv[j + 7 + sh] = {1'b1, 3'(b), 7'(r), 6'(c)};
    endtask : expect_col
    // Play one program, then let the status word cross
    task automatic run_prog(input logic [1:0] m);
        @(negedge requestClk);
        mode <= m;
        start <= 1'b1;
        @(negedge requestClk);
        start <= 1'b0;
        repeat (42) @(negedge requestClk);
        repeat (30) @(negedge clk);
    endtask : run_prog
    task automatic test_interleave();
        expv = '{default: '0};
        for (int k = 0; k < 4; k++) begin
            expect_col(4 * k + 5, 0, k, k + 1, 2 * k);
            expect_col(4 * k + 7, 0, k, k + 1, 2 * k + 1);
        end
        run_prog(2'h0);
        for (int i = 0; i < 40; i++) cmp_data(i);
        cmp_vec("status", 9'h000, {protocolError, bankOpenMask});
        $display("test_interleave done");
    endtask : test_interleave
    task automatic test_shift_miss();
        expv = '{default: '0};
        expect_col(5, 0, 5, 3, 9);
        expect_col(7, 1, 5, 3, 10);
        expect_col(23, 0, 5, 7, 1);
        run_prog(2'h1);
        for (int i = 0; i < 40; i++) cmp_data(i);
        cmp_vec("status", 9'h020, {protocolError, bankOpenMask});
        $display("test_shift_miss done");
    endtask : test_shift_miss
    task automatic test_closed_bank();
        run_prog(2'h2);
        cmp_vec("valid", 9'h003, {7'h00, rec[6].valid, rec[7].valid});
        cmp_vec("status", 9'h120, {protocolError, bankOpenMask});
        $display("test_closed_bank done");
    endtask : test_closed_bank
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // Main sequence: four clk cycles of reset, then settle the link side
    initial begin
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (10) @(negedge clk);
        test_interleave();
        test_shift_miss();
        test_closed_bank();
        tally_and_finish();
    end
    // Watchdog well beyond the three programs
    initial begin
        #50000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : drs_dram_read_sched_tb
